// >>> hdl/crlc_pkg.sv
// Purpose: shared constants and types for the reference ladder control block
// Assumes: 8-bit register data, word index addressing on a plain register port
// Notes:   level codes are in units of one ninety-sixth of the source span
package crlc_pkg;

  // register map
  localparam int unsigned        ADDR_W            = 4;
  localparam int unsigned        DATA_W            = 8;
  localparam logic [ADDR_W-1:0]  OFS_CONTROL       = 4'h0;
  localparam logic [ADDR_W-1:0]  OFS_STATUS        = 4'h1;
  localparam logic [ADDR_W-1:0]  OFS_LEVEL         = 4'h2;

  // control register field positions
  localparam int unsigned        BIT_POWER_ON      = 7;
  localparam int unsigned        BIT_PIN_DRIVE     = 6;
  localparam int unsigned        BIT_RANGE_SELECT  = 5;
  localparam int unsigned        BIT_SOURCE_SELECT = 4;
  localparam int unsigned        TAP_MSB           = 3;
  localparam int unsigned        TAP_W             = 4;

  // status register field positions
  localparam int unsigned        STS_POWERED       = 0;
  localparam int unsigned        STS_PIN_CONNECT   = 1;
  localparam int unsigned        STS_CMP_FEED      = 2;
  localparam int unsigned        STS_PORT_DRIVE    = 3;

  // reset value of the control register
  localparam logic [DATA_W-1:0]  CONTROL_RESET     = 8'h00;

  // comparator mode that routes the ladder to both comparators
  localparam logic [2:0]         CMP_MODE_INT_REF  = 3'h6;

  // level arithmetic, span divided into ninety-six parts
  localparam int unsigned        LEVEL_W           = 7;
  localparam logic [LEVEL_W-1:0] LEVEL_DENOM       = 7'h60;
  localparam logic [LEVEL_W-1:0] HIGH_BASE         = 7'h18;
  localparam logic [LEVEL_W-1:0] LOW_STEP          = 7'h04;
  localparam logic [LEVEL_W-1:0] HIGH_STEP         = 7'h03;

  // control register image, same bit order as the register
  typedef struct packed {
    logic             ladder_power_on;
    logic             ladder_pin_drive;
    logic             ladder_range_select;
    logic             ladder_source_select;
    logic [TAP_W-1:0] ladder_tap_code;
  } crlc_ctrl_t;

  // pin override bundle for port a pin 2
  typedef struct packed {
    logic ref_connect;
    logic out_enable;
    logic out_value;
  } crlc_pin_t;

endpackage

// >>> hdl/crlc_top.sv
// Purpose: control logic for a 16-tap resistor ladder voltage reference
// Assumes: single clock, registers on a plain port with read data one cycle later
// Notes:   analog ladder sits outside; this block drives its controls and pin switch
// Function
// (RL1) The top control bit powers the ladder when set and powers it down when cleared.
// (RL2) The pin drive bit connects the reference to port a pin 2 when set, disconnects when clear.
// (RL3) The pin drive bit overrides the pin 2 direction setting while it routes the reference.
// (RL4) The range bit selects the low range from zero when set, the high range from a quarter when clear.
// (RL5) The source bit selects the external reference span when set, supply span when clear.
// (RL6) A four-bit tap code from 0 to 15 selects one of sixteen levels in the chosen range.
// (RL7) Low range level is tap/24 of span; high range level is span/4 plus tap/32 of span.
// (RL8) Reset clears power, pin drive, range and tap, leaving the reference off and in high range.
// (RL9) Waking from sleep leaves every control register bit unchanged.
// (RL10) The ladder control works whatever the comparator mode, even with comparators off.
// (RL11) Software should clear the power bit before sleep to save ladder current.
// (RL12) The reference feeds both comparator positive inputs only in comparator mode 110.
// (RL13) A register write updates all ladder control outputs on the same clock edge.
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module crlc_top
  import crlc_pkg::*;
(
  input  wire logic              CLK_SYS,
  input  wire logic              SYS_RST,
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output var  logic [DATA_W-1:0] REG_RDATA,
  input  wire logic [2:0]        CMP_MODE,
  input  wire logic              PA2_DIR_INPUT,
  input  wire logic              PA2_LATCH,
  output var  crlc_ctrl_t        LADDER_CTRL,
  output var  logic [LEVEL_W-1:0] LADDER_LEVEL,
  output var  logic              CMP_REF_FEED,
  output wire logic              PA2_REF_CONNECT,
  output wire logic              PA2_OE,
  output wire logic              PA2_O
);

  // level in ninety-sixths of the span for a given control image
  function automatic logic [LEVEL_W-1:0] level_code(input crlc_ctrl_t c);
    logic [LEVEL_W-1:0] tap;
    tap = {{(LEVEL_W-TAP_W){1'b0}}, c.ladder_tap_code};
    if (!c.ladder_power_on)
      level_code = '0;
    else if (c.ladder_range_select)
      level_code = 7'(tap * LOW_STEP);
    else
      level_code = 7'(HIGH_BASE + 7'(tap * HIGH_STEP));
  endfunction

  // pin override for port a pin 2
  function automatic crlc_pin_t pin_route(input logic drive, input logic dir_in,
                                          input logic latch);
    pin_route.ref_connect = drive;
    pin_route.out_enable  = ~drive & ~dir_in;
    pin_route.out_value   = latch & ~drive;
  endfunction

  crlc_ctrl_t         control;
  crlc_ctrl_t         next_control;
  logic [DATA_W-1:0]  next_rdata;
  logic [DATA_W-1:0]  status_word;
  logic [LEVEL_W-1:0] next_level;
  logic               next_cmp_feed;
  crlc_pin_t          pin;
  wire                wr_control;
  wire                rd_control;
  wire                rd_status;
  wire                rd_level;

  // address decode
  assign wr_control = REG_WR & (REG_ADDR == OFS_CONTROL);
  assign rd_control = REG_RD & (REG_ADDR == OFS_CONTROL);
  assign rd_status  = REG_RD & (REG_ADDR == OFS_STATUS);
  assign rd_level   = REG_RD & (REG_ADDR == OFS_LEVEL);

  // whole byte taken at once; no wake or sleep input reaches this register
  // (RL13) single-edge full update
  // (RL9) no path besides writes
  assign next_control = wr_control ? crlc_ctrl_t'(REG_WDATA) : control;

  // (RL8) reset clears all fields
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      control <= crlc_ctrl_t'(CONTROL_RESET);
    else
      control <= next_control;
  end

  // (RL1) power bit to ladder
  // (RL4) range bit to ladder
  // (RL5) source bit to ladder
  // (RL6) tap code to ladder
  assign LADDER_CTRL = control;

  // (RL7) level from range and tap
  assign next_level = level_code(next_control);

  // power gate keeps a dark ladder off the comparators
  // (RL12) comparator feed in mode 110 only
  // (RL10) ladder state independent of mode
  assign next_cmp_feed = (CMP_MODE == CMP_MODE_INT_REF) & next_control.ladder_power_on;

  // level and feed registered beside control so all change together
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      LADDER_LEVEL <= '0;
      CMP_REF_FEED <= 1'b0;
    end
    else
    begin
      LADDER_LEVEL <= next_level;
      CMP_REF_FEED <= next_cmp_feed;
    end
  end

  // combinational so switch and driver never overlap for a cycle
  // (RL2) reference switch to pin
  // (RL3) override of pin direction
  assign pin             = pin_route(control.ladder_pin_drive, PA2_DIR_INPUT, PA2_LATCH);
  assign PA2_REF_CONNECT = pin.ref_connect;
  assign PA2_OE          = pin.out_enable;
  assign PA2_O           = pin.out_value;

  // status word, reserved bits zero
  always_comb
  begin
    status_word                  = '0;
    status_word[STS_POWERED]     = control.ladder_power_on;
    status_word[STS_PIN_CONNECT] = pin.ref_connect;
    status_word[STS_CMP_FEED]    = CMP_REF_FEED;
    status_word[STS_PORT_DRIVE]  = pin.out_enable;
  end

  // zero between reads lets several slaves share an or-ed bus
  // read mux; unmapped addresses read zero
  assign next_rdata = rd_control ? DATA_W'(control) :
                      rd_status  ? status_word :
                      rd_level   ? {{(DATA_W-LEVEL_W){1'b0}}, LADDER_LEVEL} :
                      '0;

  // read data held only in the cycle after the strobe
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      REG_RDATA <= '0;
    else
      REG_RDATA <= next_rdata;
  end

  // checks
  default clocking dc @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);

  // helper: expected level computed independently of the function
  logic [LEVEL_W-1:0] exp_level;
  always_comb
  begin
    exp_level = '0;
    if (LADDER_CTRL.ladder_power_on)
    begin
      if (LADDER_CTRL.ladder_range_select)
        exp_level = {1'b0, LADDER_CTRL.ladder_tap_code, 2'b00};
      else
        exp_level = 7'(HIGH_BASE + {3'b000, LADDER_CTRL.ladder_tap_code}
                       + {2'b00, LADDER_CTRL.ladder_tap_code, 1'b0});
    end
  end

  // (RL1) power bit follows write
  power_follows_a: assert property (wr_control |=>
      LADDER_CTRL.ladder_power_on == $past(REG_WDATA[BIT_POWER_ON])) // RL1
    else $error("power bit did not follow write");

  // (RL2) pin switch follows pin drive bit
  pin_switch_a: assert property (wr_control |=>
      PA2_REF_CONNECT == $past(REG_WDATA[BIT_PIN_DRIVE])) // RL2
    else $error("pin switch does not match pin drive bit");

  // (RL3) port driver off while reference routed
  pin_override_a: assert property (PA2_REF_CONNECT |-> !PA2_OE && !PA2_O) // RL3
    else $error("port driver active while reference on pin");

  // (RL4) range bit lands in its slot
  range_follows_a: assert property (wr_control |=>
      LADDER_CTRL.ladder_range_select == $past(REG_WDATA[BIT_RANGE_SELECT])) // RL4
    else $error("range select did not follow write");

  // (RL5) source bit lands in its slot
  source_follows_a: assert property (wr_control |=>
      LADDER_CTRL.ladder_source_select == $past(REG_WDATA[BIT_SOURCE_SELECT])) // RL5
    else $error("source select did not follow write");

  // (RL6) tap code lands in low bits
  tap_follows_a: assert property (wr_control |=>
      LADDER_CTRL.ladder_tap_code == $past(REG_WDATA[TAP_MSB:0])) // RL6
    else $error("tap code did not follow write");

  // (RL7) level matches range equation
  level_value_a: assert property (LADDER_LEVEL == exp_level) // RL7
    else $error("ladder level does not match range equation");

  // (RL7) level never reaches the full span
  level_bound_a: assert property (LADDER_LEVEL < LEVEL_DENOM) // RL7
    else $error("ladder level out of span");

  // (RL8) reset release leaves all fields clear
  reset_clear_a: assert property ($fell(SYS_RST) |->
      LADDER_CTRL == crlc_ctrl_t'(CONTROL_RESET)) // RL8
    else $error("control not clear after reset");

  // (RL9) register holds without a write
  hold_value_a: assert property (!wr_control |=> $stable(LADDER_CTRL)) // RL9
    else $error("control changed without a write");

  // (RL10) comparator mode never alters controls
  mode_indep_a: assert property ($changed(CMP_MODE) && !wr_control |=>
      $stable(LADDER_CTRL) && $stable(LADDER_LEVEL)) // RL10
    else $error("comparator mode disturbed ladder controls");

  // (RL12) feed only in internal reference mode
  cmp_feed_a: assert property (
      CMP_REF_FEED == ($past(CMP_MODE) == CMP_MODE_INT_REF
                       && LADDER_CTRL.ladder_power_on)) // RL12
    else $error("comparator feed wrong for mode");

  // (RL13) level and controls change on one edge
  same_edge_a: assert property ($changed(LADDER_CTRL) && LADDER_CTRL.ladder_power_on
      |-> LADDER_LEVEL == exp_level) // RL13
    else $error("level lagged control update");

  // read data shows control one cycle after read
  read_back_a: assert property (rd_control |=> REG_RDATA == DATA_W'($past(LADDER_CTRL)))
    else $error("control readback wrong");

  // helper: last image written; catches any path besides writes
  crlc_ctrl_t last_image;
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      last_image <= crlc_ctrl_t'(CONTROL_RESET);
    else if (wr_control)
      last_image <= crlc_ctrl_t'(REG_WDATA);
  end

  // helper: idle run since last write, saturates so it never wraps
  logic [7:0] idle_run;
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      idle_run <= 8'h00;
    else if (wr_control)
      idle_run <= 8'h00;
    else if (idle_run != 8'hFF)
      idle_run <= idle_run + 8'h01;
  end

  // (RL9) control equals the last written image
  image_hold_a: assert property (LADDER_CTRL == last_image) // RL9
    else $error("control differs from last written image");

  // (RL9) writes elsewhere leave control alone
  foreign_write_a: assert property (REG_WR && !wr_control |=> $stable(LADDER_CTRL)) // RL9
    else $error("control changed on a foreign write");

  // (RL1) dark ladder shows no level and no feed
  power_off_a: assert property (!LADDER_CTRL.ladder_power_on |->
      LADDER_LEVEL == 7'h00 && !CMP_REF_FEED) // RL1
    else $error("level or feed present while powered down");

  // (RL3) driver enable follows direction only while unrouted
  pin_oe_a: assert property (PA2_OE == (!PA2_REF_CONNECT && !PA2_DIR_INPUT)) // RL3
    else $error("port driver enable wrong");

  // (RL2) driver value gated off while routed
  pin_value_a: assert property (PA2_O == (PA2_LATCH && !PA2_REF_CONNECT)) // RL2
    else $error("port driver value wrong");

  // (RL4) low range stays within zero to top tap
  low_span_a: assert property (LADDER_CTRL.ladder_power_on && LADDER_CTRL.ladder_range_select
      |-> LADDER_LEVEL <= 7'h3C) // RL4
    else $error("low range level out of bounds");

  // (RL4) high range stays within quarter to top tap
  high_span_a: assert property (LADDER_CTRL.ladder_power_on && !LADDER_CTRL.ladder_range_select
      |-> LADDER_LEVEL >= HIGH_BASE && LADDER_LEVEL <= 7'h45) // RL4
    else $error("high range level out of bounds");

  // (RL5) source bit alone never moves the level
  source_only_a: assert property ($changed(LADDER_CTRL.ladder_source_select)
      && $stable(LADDER_CTRL.ladder_tap_code) && $stable(LADDER_CTRL.ladder_range_select)
      && $stable(LADDER_CTRL.ladder_power_on) |-> $stable(LADDER_LEVEL)) // RL5
    else $error("source select moved the level");

  // (RL6) one tap up in high range adds one step
  tap_step_a: assert property (LADDER_CTRL.ladder_power_on && !LADDER_CTRL.ladder_range_select
      && $past(LADDER_CTRL.ladder_power_on) && !$past(LADDER_CTRL.ladder_range_select)
      && LADDER_CTRL.ladder_tap_code == 4'($past(LADDER_CTRL.ladder_tap_code) + 4'h1)
      && LADDER_CTRL.ladder_tap_code != 4'h0
      |-> LADDER_LEVEL == 7'($past(LADDER_LEVEL) + HIGH_STEP)) // RL6
    else $error("high range tap step wrong");

  // (RL8) outputs quiet on reset release
  reset_quiet_a: assert property ($fell(SYS_RST) |->
      LADDER_LEVEL == 7'h00 && !CMP_REF_FEED && !PA2_REF_CONNECT) // RL8
    else $error("outputs active after reset");

  // (RL12) no feed outside the shared-input mode
  feed_mode_only_a: assert property ($past(CMP_MODE) != CMP_MODE_INT_REF |-> !CMP_REF_FEED) // RL12
    else $error("feed outside shared-input mode");

  // read data zero after a cycle without a read
  rdata_idle_a: assert property (!REG_RD |=> REG_RDATA == 8'h00)
    else $error("read data not zero between reads");

  // status read returns the live status word
  status_read_a: assert property (rd_status |=> REG_RDATA == $past(status_word))
    else $error("status readback wrong");

  // level read returns the registered level
  level_read_a: assert property (rd_level |=> REG_RDATA == {1'b0, $past(LADDER_LEVEL)})
    else $error("level readback wrong");

  // main scenarios
  low_range_c:  cover property (wr_control ##1
      LADDER_CTRL.ladder_power_on && LADDER_CTRL.ladder_range_select);
  high_range_c: cover property (wr_control ##1
      LADDER_CTRL.ladder_power_on && !LADDER_CTRL.ladder_range_select);
  pin_drive_c:  cover property (PA2_REF_CONNECT && !PA2_DIR_INPUT);
  cmp_feed_c:   cover property (CMP_REF_FEED ##1 rd_status);
  long_idle_c:  cover property (idle_run == 8'h10);

endmodule

`default_nettype wire

// >>> testbench/crlc_ladder_model.sv
// Purpose: far side model, analog ladder taps and the shared pin 2 node
// Assumes: level counted in ninety-sixths of the source span
// Notes:   an undriven pin shows 7F, never the last level
`timescale 1ns/1ns
`default_nettype none

module crlc_ladder_model
  import crlc_pkg::*;
(
  input  wire logic              connect,
  input  wire logic              oe,
  input  wire crlc_ctrl_t        ctrl,
  output var  logic [LEVEL_W-1:0] pin_lvl,
  output var  logic              clash
);
  logic [LEVEL_W-1:0] tap_lvl;
  assign tap_lvl = ctrl.ladder_range_select ? {1'b0, ctrl.ladder_tap_code, 2'b00}
                 : 7'h18 + 7'(ctrl.ladder_tap_code) * 7'h03;
  assign pin_lvl = (connect && ctrl.ladder_power_on) ? tap_lvl : 7'h7F;
  assign clash = connect & oe;
endmodule

`default_nettype wire

// >>> testbench/tb_crlc_top.sv
// Purpose: self-checking bench for the reference ladder control block
// Assumes: register port with read data one cycle after the strobe
// Notes:   comparators left off (mode 7) unless a scenario says otherwise
`timescale 1ns/1ns
`default_nettype none

module tb_crlc_top;
  import crlc_pkg::*;
  logic               clk_sys = 1'b0;
  logic               sys_rst = 1'b1;
  logic [ADDR_W-1:0]  reg_addr = '0;
  logic [DATA_W-1:0]  reg_wdata = '0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [DATA_W-1:0]  reg_rdata;
  logic [2:0]         cmp_mode = 3'h7;
  logic               pa2_dir_input = 1'b0;
  logic               pa2_latch = 1'b1;
  crlc_ctrl_t         ladder_ctrl;
  logic [LEVEL_W-1:0] ladder_level;
  logic [LEVEL_W-1:0] pin_lvl;
  logic               cmp_ref_feed, pa2_ref_connect, pa2_oe, pa2_o, clash;
  int                 err_total = 0;
  int                 num_checks = 0;
  int                 cycles = 0;
  logic [DATA_W-1:0]  rv;

  always #4 clk_sys = ~clk_sys;

  crlc_top u_crlc_top (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .CMP_MODE(cmp_mode), .PA2_DIR_INPUT(pa2_dir_input), .PA2_LATCH(pa2_latch),
    .LADDER_CTRL(ladder_ctrl), .LADDER_LEVEL(ladder_level), .CMP_REF_FEED(cmp_ref_feed),
    .PA2_REF_CONNECT(pa2_ref_connect), .PA2_OE(pa2_oe), .PA2_O(pa2_o));

  crlc_ladder_model u_crlc_ladder_model (.connect(pa2_ref_connect), .oe(pa2_oe),
    .ctrl(ladder_ctrl), .pin_lvl(pin_lvl), .clash(clash));

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // walks both ranges and every tap with comparators off
  task automatic t_taps;
    logic [7:0] d;
    for (int r = 0; r < 2; r++)
      for (int t = 0; t < 16; t++)
      begin
        d = {1'b1, 1'b0, r[0], 1'b0, t[3:0]};
        wr(OFS_CONTROL, d);
        chk("ctrl", d, ladder_ctrl);
        chk("level", {1'b0, r ? 7'(t * 4) : 7'(24 + t * 3)}, {1'b0, ladder_level});
      end
    rd(OFS_CONTROL, rv);
    chk("readback", 8'hAF, rv);
    rd(OFS_LEVEL, rv);
    chk("level reg", 8'h3C, rv);
    @(posedge clk_sys);
    #1 chk("rdata idle", 8'h00, reg_rdata);
    wr(OFS_CONTROL, 8'h1F);
    chk("ctrl", 8'h1F, ladder_ctrl);
    chk("level", 8'h00, {1'b0, ladder_level});
  endtask

  task automatic t_pin;
    wr(OFS_CONTROL, 8'hC3);
    chk("connect oe o clash", 8'h08, {pa2_ref_connect, pa2_oe, pa2_o, clash});
    chk("pin", 8'h21, {1'b0, pin_lvl});
    @(posedge clk_sys);
    pa2_dir_input <= 1'b1;
    #1 chk("dir in connect oe", 8'h02, {pa2_ref_connect, pa2_oe});
    @(posedge clk_sys);
    pa2_dir_input <= 1'b0;
    wr(OFS_CONTROL, 8'h80);
    chk("connect oe o", 8'h03, {pa2_ref_connect, pa2_oe, pa2_o});
    @(posedge clk_sys);
    pa2_dir_input <= 1'b1;
    #1 chk("dir in connect oe o", 8'h01, {pa2_ref_connect, pa2_oe, pa2_o});
    @(posedge clk_sys);
    pa2_dir_input <= 1'b0;
  endtask

  task automatic t_cmp;
    for (int m = 0; m < 8; m++)
    begin
      @(posedge clk_sys);
      cmp_mode <= m[2:0];
      @(posedge clk_sys);
      #1 chk("feed", {7'h00, m == 6}, {7'h00, cmp_ref_feed});
      if (m == 6)
      begin
        rd(OFS_STATUS, rv);
        chk("status", 8'h0D, rv);
      end
    end
    @(posedge clk_sys);
    cmp_mode <= 3'h7;
  endtask

  task automatic t_bus_sleep;
    wr(4'hF, 8'h55);
    wr(OFS_STATUS, 8'hFF);
    rd(OFS_CONTROL, rv);
    chk("control", 8'h80, rv);
    rd(4'hF, rv);
    chk("unmapped", 8'h00, rv);
    wr(OFS_CONTROL, 8'h00);
    repeat (20) @(posedge clk_sys);
    #1 chk("idle ctrl", 8'h00, ladder_ctrl);
    wr(OFS_CONTROL, 8'hEF);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1 chk("ctrl", 8'h00, ladder_ctrl);
    chk("oe connect", 8'h01, {pa2_ref_connect, pa2_oe});
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    // budget well above the roughly 135 cycles the scenarios need
    if (cycles == 5000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1 chk("reset ctrl", 8'h00, ladder_ctrl);
    t_taps();
    t_pin();
    t_cmp();
    t_bus_sleep();
    report_and_stop();
  end
endmodule

`default_nettype wire
